// *** common/uart_status_pkg.sv ***
// Purpose: Shared constants for the UART line and modem status block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package uart_status_pkg;

  localparam int          AddrW          = 4;
  localparam logic [3:0]  OffLineStatus  = 4'h0;
  localparam logic [3:0]  OffModemStatus = 4'h4;
  localparam logic [3:0]  OffScratchpad  = 4'h8;
  localparam logic [3:0]  OffModemCtrl   = 4'hc;

  // Line status bits
  localparam int          LsrReady       = 0;
  localparam int          LsrOverrun     = 1;
  // Modem status bits
  localparam int          MsrDeltaCts    = 0;
  localparam int          MsrDeltaDsr    = 1;
  localparam int          MsrRingEnd     = 2;
  localparam int          MsrDeltaCd     = 3;
  // Modem control bits
  localparam int          McrDtr         = 0;
  localparam int          McrRts         = 1;
  localparam int          McrOutOne      = 2;
  localparam int          McrOutTwo      = 3;
  localparam int          McrLoop        = 4;

  localparam logic [7:0]  ScratchReset   = 8'h00;
  localparam logic [4:0]  ModemCtrlReset = 5'h00;
  localparam int          SyncStages     = 2;
  localparam int          FifoDepth      = 16;

  localparam logic [1:0]  RespOkay       = 2'h0;
  localparam logic [1:0]  RespSlvErr     = 2'h2;

endpackage

// *** logic/modem_input_sync.sv ***
// Purpose: Two-stage synchroniser for the four modem control inputs
// Assumes: Inputs are asynchronous to core_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ns
module modem_input_sync #(
  parameter int Width = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Levels
  input  wire logic [Width-1:0] rawIn,
  output logic      [Width-1:0] syncOut
);

  logic [Width-1:0] metaQ;

  // [R13] two flop sync
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      metaQ   <= '1;
      syncOut <= '1;
    end else begin
      metaQ   <= rawIn;
      syncOut <= metaQ;
    end
  end

endmodule

// *** logic/uart_line_modem_status.sv ***
// Purpose: Receive FIFO status, modem status and scratchpad of one channel
// Assumes: AXI4-Lite slave, one outstanding write and one read
// Notes:   Modem inputs are active low at the pins
`timescale 1ns/1ns
// Overview of operation
// [R1] Overrun flag when char completes, FIFO full
// [R2] Overrun char dropped, FIFO left intact
// [R3] Data ready while FIFO holds data
// [R4] Bit7 is not carrier, loop shows output two
// [R5] Bit6 is not ring, loop shows output one
// [R6] Bit5 is not DSR, loop shows DTR
// [R7] Bit4 is not CTS, loop shows RTS
// [R8] Delta flags for CD, DSR, CTS toggles
// [R9] Ring flag only on rising input
// [R10] Reading modem status clears change flags
// [R11] Interrupt request while any change flag
// [R12] Scratchpad stores eight host bits
// [R13] Modem inputs synchronised before edge detect
module uart_line_modem_status
  import uart_status_pkg::*;
#(
  parameter int Depth = FifoDepth
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // AXI4-Lite write address
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [AddrW-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  // AXI4-Lite write response
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [AddrW-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  // Receiver side
  input  wire logic             rxCharDone,
  input  wire logic             rxFifoPop,
  output logic                  rxFifoPush,
  // Modem control inputs, active low
  input  wire logic             cdN,
  input  wire logic             riN,
  input  wire logic             dsrN,
  input  wire logic             ctsN,
  // Modem control outputs, active low
  output logic                  dtrN,
  output logic                  rtsN,
  output logic                  userOutputOneN,
  output logic                  userOutputTwoN,
  // Modem status interrupt request
  output logic                  modemIrq
);

  initial begin
    if (Depth < 1 || Depth > 255)
      $error("Depth out of range");
  end

  logic [3:0] pinSync;
  logic [7:0] countQ, countD;
  logic       overrunQ, overrunD;
  logic       pushQ, pushD;
  logic [3:0] levelQ, levelD;
  logic [3:0] deltaQ, deltaD;
  logic [7:0] scratchQ, scratchD;
  logic [4:0] mctrlQ, mctrlD;
  logic [3:0] level;
  logic       fifoFull;
  logic       accept;
  logic       rdMsr, rdLsr;

  // Write channel state
  logic             awHeldQ, awHeldD, wHeldQ, wHeldD;
  logic [AddrW-1:0] awAddrQ, awAddrD;
  logic [31:0]      wDataQ, wDataD;
  logic [3:0]       wStrbQ, wStrbD;
  logic             bvalidQ, bvalidD;
  logic [1:0]       brespQ, brespD;
  // Read channel state
  logic             rvalidQ, rvalidD;
  logic [31:0]      rdataQ, rdataD;
  logic [1:0]       rrespQ, rrespD;
  logic             doWrite, doRead;
  // Ready outputs kept in flops so every port leaves a register
  logic             awRdyQ, wRdyQ, arRdyQ;

  // [R13] sync inputs
  modem_input_sync #(.Width(4)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .rawIn    ({cdN, riN, dsrN, ctsN}),
    .syncOut  (pinSync)
  );

  // [R4] [R5] [R6] [R7] loopback select
  always_comb begin
    if (mctrlQ[McrLoop]) begin
      level = {mctrlQ[McrOutTwo], mctrlQ[McrOutOne],
               mctrlQ[McrDtr], mctrlQ[McrRts]};
    end else begin
      level = ~pinSync;
    end
  end

  assign fifoFull = (countQ == 8'(Depth));
  assign accept   = s_axi_arvalid && !rvalidQ;
  assign rdMsr    = accept && (s_axi_araddr == OffModemStatus);
  assign rdLsr    = accept && (s_axi_araddr == OffLineStatus);
  assign doWrite  = awHeldQ && wHeldQ && !bvalidQ;
  assign doRead   = accept;

  // Receive status and modem state
  always_comb begin
    countD   = countQ;
    overrunD = overrunQ;
    pushD    = 1'b0;
    levelD   = level;
    deltaD   = deltaQ;
    // [R2] drop when full
    if (rxCharDone && !fifoFull) begin
      pushD = 1'b1;
    end
    if (pushD && !(rxFifoPop && countQ != 8'h00)) begin
      countD = countQ + 8'h01;
    end else if (!pushD && rxFifoPop && countQ != 8'h00) begin
      countD = countQ - 8'h01;
    end
    // Overrun clears on read of line status, set wins
    if (rdLsr) begin
      overrunD = 1'b0;
    end
    // [R1] overrun on full
    if (rxCharDone && fifoFull) begin
      overrunD = 1'b1;
    end
    // [R10] read clears deltas
    if (rdMsr) begin
      deltaD = 4'h0;
    end
    // [R8] toggle detection
    if (level[3] != levelQ[3]) deltaD[MsrDeltaCd]  = 1'b1;
    if (level[1] != levelQ[1]) deltaD[MsrDeltaDsr] = 1'b1;
    if (level[0] != levelQ[0]) deltaD[MsrDeltaCts] = 1'b1;
    // [R9] ring input rises: ring bit falls
    if (levelQ[2] && !level[2]) deltaD[MsrRingEnd] = 1'b1;
  end

  // Register writes
  always_comb begin
    scratchD = scratchQ;
    mctrlD   = mctrlQ;
    if (doWrite && wStrbQ[0]) begin
      // [R12] scratchpad store
      if (awAddrQ == OffScratchpad) scratchD = wDataQ[7:0];
      if (awAddrQ == OffModemCtrl)  mctrlD   = wDataQ[4:0];
    end
  end

  // AXI handshake and read mux
  always_comb begin
    awHeldD = awHeldQ;
    awAddrD = awAddrQ;
    wHeldD  = wHeldQ;
    wDataD  = wDataQ;
    wStrbD  = wStrbQ;
    bvalidD = bvalidQ;
    brespD  = brespQ;
    rvalidD = rvalidQ;
    rdataD  = rdataQ;
    rrespD  = rrespQ;
    if (s_axi_awvalid && !awHeldQ) begin
      awHeldD = 1'b1;
      awAddrD = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeldQ) begin
      wHeldD = 1'b1;
      wDataD = s_axi_wdata;
      wStrbD = s_axi_wstrb;
    end
    if (doWrite) begin
      awHeldD = 1'b0;
      wHeldD  = 1'b0;
      bvalidD = 1'b1;
      brespD  = (awAddrQ == OffScratchpad || awAddrQ == OffModemCtrl)
                ? RespOkay : RespSlvErr;
    end
    if (bvalidQ && s_axi_bready) bvalidD = 1'b0;
    if (rvalidQ && s_axi_rready) rvalidD = 1'b0;
    if (doRead) begin
      rvalidD = 1'b1;
      rrespD  = RespOkay;
      case (s_axi_araddr)
        // [R3] data ready bit
        OffLineStatus:  rdataD = {30'h0, overrunQ, countQ != 8'h00};
        OffModemStatus: rdataD = {24'h0, levelQ, deltaQ};
        OffScratchpad:  rdataD = {24'h0, scratchQ};
        OffModemCtrl:   rdataD = {27'h0, mctrlQ};
        default: begin
          rdataD = 32'h0;
          rrespD = RespSlvErr;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      countQ   <= 8'h00;
      overrunQ <= 1'b0;
      pushQ    <= 1'b0;
      levelQ   <= 4'h0;
      deltaQ   <= 4'h0;
      scratchQ <= ScratchReset;
      mctrlQ   <= ModemCtrlReset;
      awHeldQ  <= 1'b0;
      awAddrQ  <= '0;
      wHeldQ   <= 1'b0;
      wDataQ   <= 32'h0;
      wStrbQ   <= 4'h0;
      bvalidQ  <= 1'b0;
      brespQ   <= RespOkay;
      rvalidQ  <= 1'b0;
      rdataQ   <= 32'h0;
      rrespQ   <= RespOkay;
    end else begin
      countQ   <= countD;
      overrunQ <= overrunD;
      pushQ    <= pushD;
      levelQ   <= levelD;
      deltaQ   <= deltaD;
      scratchQ <= scratchD;
      mctrlQ   <= mctrlD;
      awHeldQ  <= awHeldD;
      awAddrQ  <= awAddrD;
      wHeldQ   <= wHeldD;
      wDataQ   <= wDataD;
      wStrbQ   <= wStrbD;
      bvalidQ  <= bvalidD;
      brespQ   <= brespD;
      rvalidQ  <= rvalidD;
      rdataQ   <= rdataD;
      rrespQ   <= rrespD;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modemIrq       <= 1'b0;
      awRdyQ         <= 1'b1;
      wRdyQ          <= 1'b1;
      arRdyQ         <= 1'b1;
      dtrN           <= 1'b1;
      rtsN           <= 1'b1;
      userOutputOneN <= 1'b1;
      userOutputTwoN <= 1'b1;
    end else begin
      // [R11] irq on deltas
      modemIrq       <= |deltaD;
      awRdyQ         <= !awHeldD;
      wRdyQ          <= !wHeldD;
      arRdyQ         <= !rvalidD;
      // Loopback keeps pins inactive
      dtrN           <= ~mctrlD[McrDtr] | mctrlD[McrLoop];
      rtsN           <= ~mctrlD[McrRts] | mctrlD[McrLoop];
      userOutputOneN <= ~mctrlD[McrOutOne] | mctrlD[McrLoop];
      userOutputTwoN <= ~mctrlD[McrOutTwo] | mctrlD[McrLoop];
    end
  end

  assign s_axi_awready = awRdyQ;
  assign s_axi_wready  = wRdyQ;
  assign s_axi_bvalid  = bvalidQ;
  assign s_axi_bresp   = brespQ;
  assign s_axi_arready = arRdyQ;
  assign s_axi_rvalid  = rvalidQ;
  assign s_axi_rdata   = rdataQ;
  assign s_axi_rresp   = rrespQ;
  assign rxFifoPush    = pushQ;

  sequence s_full_done;
    rxCharDone && fifoFull;
  endsequence

  a_overrun_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_full_done |=> overrunQ && !pushQ) // [R1]
    else $error("overrun not flagged");
  a_full_no_push: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_full_done |=> !rxFifoPush &&
    countQ == $past(countQ) - 8'($past(rxFifoPop))) // [R2]
    else $error("fifo touched on overrun");
  a_ready_bit: assert property (@(posedge core_clk) disable iff (sys_rst)
    rdLsr |=> rdataQ[LsrReady] == ($past(countQ) != 8'h00)) // [R3]
    else $error("data ready wrong");
  a_cd_loop: assert property (@(posedge core_clk) disable iff (sys_rst)
    mctrlQ[McrLoop] && $stable(mctrlQ)
    |=> levelQ[3] == $past(mctrlQ[McrOutTwo])) // [R4]
    else $error("cd loop mismatch");
  a_ri_loop: assert property (@(posedge core_clk) disable iff (sys_rst)
    mctrlQ[McrLoop] && $stable(mctrlQ)
    |=> levelQ[2] == $past(mctrlQ[McrOutOne])) // [R5]
    else $error("ri loop mismatch");
  a_dsr_norm: assert property (@(posedge core_clk) disable iff (sys_rst)
    !mctrlQ[McrLoop] |=> levelQ[1] == ~$past(pinSync[1])) // [R6]
    else $error("dsr level wrong");
  a_cts_norm: assert property (@(posedge core_clk) disable iff (sys_rst)
    !mctrlQ[McrLoop] |=> levelQ[0] == ~$past(pinSync[0])) // [R7]
    else $error("cts level wrong");
  a_cts_delta: assert property (@(posedge core_clk) disable iff (sys_rst)
    level[0] != levelQ[0] |=> deltaQ[MsrDeltaCts]) // [R8]
    else $error("cts change lost");
  a_ri_fall: assert property (@(posedge core_clk) disable iff (sys_rst)
    !levelQ[2] && level[2] && !deltaQ[2] |=> !deltaQ[MsrRingEnd]) // [R9]
    else $error("ri wrong edge");
  a_msr_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    rdMsr && level == levelQ |=> deltaQ == 4'h0) // [R10]
    else $error("deltas not cleared");
  a_irq_track: assert property (@(posedge core_clk) disable iff (sys_rst)
    modemIrq == (|deltaQ)) // [R11]
    else $error("irq mismatch");
  a_scratch_wr: assert property (@(posedge core_clk) disable iff (sys_rst)
    doWrite && wStrbQ[0] && awAddrQ == OffScratchpad
    |=> scratchQ == $past(wDataQ[7:0])) // [R12]
    else $error("scratch not stored");

endmodule

// *** bench/modem_peer.sv ***
// Purpose: Modem side model driving the four active low status pins
// Assumes: Bench commands asserted levels, one bit per line
// Notes:   Pins change only just after a clock edge, like a real peer
`timescale 1ns/1ns
module modem_peer (
  // Clock
  input  wire logic       core_clk,
  // Commanded levels: cd, ri, dsr, cts
  input  wire logic [3:0] active,
  // Pins, active low
  output logic            cdN,
  output logic            riN,
  output logic            dsrN,
  output logic            ctsN
);
  initial {cdN, riN, dsrN, ctsN} = 4'hf;
  always @(posedge core_clk) begin
    {cdN, riN, dsrN, ctsN} <= #2 ~active;
  end
endmodule

// *** bench/uart_line_modem_status_bench.sv ***
// Purpose: Self-checking bench for the line and modem status block
// Assumes: AXI4-Lite master tasks, receive depth shortened to 4
// Notes:   Modem pins come from modem_peer
`timescale 1ns/1ns
module uart_line_modem_status_bench;
  import uart_status_pkg::*;
  localparam int D = 4;
  logic             core_clk = 0, sys_rst = 1;
  logic             awv = 0, wv = 0, bv, arv = 0, rv, br = 0, rr = 0;
  logic             awr, wr, arr, rxDone = 0, rxPop = 0, push, irq;
  logic [AddrW-1:0] awa = '0, ara = '0;
  logic [31:0]      wd = '0, rd;
  logic [1:0]       bresp, rresp;
  logic [3:0]       act = '0, outsN;
  logic             cdN, riN, dsrN, ctsN;
  logic [31:0]      v;
  logic [1:0]       rs;
  int               miscompares = 0, n_compared = 0, pushes = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (push === 1'b1) pushes++;
  modem_peer PEER (.core_clk(core_clk), .active(act), .cdN(cdN),
    .riN(riN), .dsrN(dsrN), .ctsN(ctsN));
  uart_line_modem_status #(.Depth(D)) DUT (.core_clk(core_clk),
    .sys_rst(sys_rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .rxCharDone(rxDone), .rxFifoPop(rxPop), .rxFifoPush(push),
    .cdN(cdN), .riN(riN), .dsrN(dsrN), .ctsN(ctsN), .dtrN(outsN[0]),
    .rtsN(outsN[1]), .userOutputOneN(outsN[2]),
    .userOutputTwoN(outsN[3]), .modemIrq(irq));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr32(logic [3:0] a, logic [31:0] d);
    int n;
    n = 0;
    awv <= 1; awa <= a; wv <= 1; wd <= d; br <= 1;
    while (n < 50) begin
      @(posedge core_clk);
      n++;
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
      if (bv === 1'b1) break;
    end
    br <= 0;
    chk("bvalid", 32'h1, {31'h0, bv});
    chk("bresp", RespOkay, {30'h0, bresp});
  endtask
  task automatic rd32(logic [3:0] a, output logic [31:0] d);
    int n;
    n = 0;
    arv <= 1; ara <= a; rr <= 1;
    while (n < 50) begin
      @(posedge core_clk);
      n++;
      if (arv && arr) arv <= 0;
      if (rv === 1'b1) break;
    end
    d = rd;
    rs = rresp;
    rr <= 0;
    chk("rvalid", 32'h1, {31'h0, rv});
    @(posedge core_clk);
  endtask
  task automatic rdchk(string n, logic [3:0] a, logic [31:0] e);
    rd32(a, v);
    chk(n, e, v);
    chk("rresp", RespOkay, {30'h0, rs});
  endtask
  task automatic pulse(bit pop);
    if (pop) rxPop <= 1;
    else rxDone <= 1;
    @(posedge core_clk);
    rxPop <= 0;
    rxDone <= 0;
    @(posedge core_clk);
  endtask
  task automatic t_reset();
    rdchk("line_status", OffLineStatus, 32'h0);
    rdchk("modem_status", OffModemStatus, 32'h0);
    rdchk("scratchpad", OffScratchpad, {24'h0, ScratchReset});
    rd32(4'h1, v);
    chk("rdata", 32'h0, v);
    chk("rresp", RespSlvErr, {30'h0, rs});
  endtask
  task automatic t_scratch();
    wr32(OffScratchpad, 32'hffff_ffa5);
    rdchk("scratchpad", OffScratchpad, 32'ha5);
    rdchk("line_status", OffLineStatus, 32'h0);
  endtask
  // Fill to depth, one extra character overruns
  task automatic t_fifo();
    repeat (D + 1) pulse(1'b0);
    @(posedge core_clk);
    chk("pushes", D, pushes);
    rdchk("line_status", OffLineStatus, 32'h3);
    rdchk("line_status", OffLineStatus, 32'h1);
    repeat (D - 1) pulse(1'b1);
    rdchk("line_status", OffLineStatus, 32'h1);
    pulse(1'b1);
    rdchk("line_status", OffLineStatus, 32'h0);
  endtask
  task automatic t_line(int i, logic [7:0] onV, logic [7:0] offV);
    act[i] <= 1;
    repeat (6) @(posedge core_clk);
    chk("irq", {31'h0, |onV[3:0]}, {31'h0, irq});
    rdchk("modem_status", OffModemStatus, onV);
    chk("irq", 32'h0, {31'h0, irq});
    rdchk("modem_status", OffModemStatus, onV & 8'hf0);
    act[i] <= 0;
    repeat (6) @(posedge core_clk);
    rdchk("modem_status", OffModemStatus, offV);
    rdchk("modem_status", OffModemStatus, 32'h0);
  endtask
  // Loopback shows control bits, pins stay inactive
  task automatic t_loop();
    wr32(OffModemCtrl, 32'h0f);
    chk("outsN", 32'h0, {28'h0, outsN});
    rdchk("modem_status", OffModemStatus, 32'h0);
    wr32(OffModemCtrl, 32'h1f);
    chk("outsN", 32'hf, {28'h0, outsN});
    rdchk("modem_status", OffModemStatus, 32'hfb);
    wr32(OffModemCtrl, 32'h14);
    rdchk("modem_status", OffModemStatus, 32'h4b);
    wr32(OffModemCtrl, 32'h10);
    rdchk("modem_status", OffModemStatus, 32'h04);
    wr32(OffModemCtrl, 32'h00);
    rdchk("modem_status", OffModemStatus, 32'h00);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    t_reset();
    t_scratch();
    t_fifo();
    t_line(3, 8'h88, 8'h08);
    t_line(2, 8'h40, 8'h04);
    t_line(1, 8'h22, 8'h02);
    t_line(0, 8'h11, 8'h01);
    t_loop();
    complete_run();
  end
endmodule
